/* src/tpm_serializer.sv */
`timescale 1ns/1ns
// Operation
// - five data stages loaded parallel from matrix
// - load when phase clears transfer flag
// - idle flags and stages at rest values
// - step with empty clear sets running
// - running sets transfer, start unit space
// - load on phase two, shift half later
// - one shift per bit toward output
// - empty when stop mark at output
// - empty blocks step, shifting; base runs
// - running clears half bit after empty
// - running clear: mark, reload stop stage
// - stop mark reloaded ends empty condition
// - default stop clears empty half later
// - long stop clears empty one bit later
// - run mode chains frames back to back
// - reversals toggle output, force running
// - steady mark ignores all start requests
// - units counter advances on running clear
// - BCD counters, tens on units nine
// - length reset clears counters and burst
// - power-up reset loads counters in its own branch, not via cnt_clr
// - table eighty entries of five bits
// - step mode: one character per pulse
// - burst flag sends until length reset
module tpm_serializer
	import tpm_pkg::*;
#(
	parameter logic [DIV_W-1:0] HALF_BIT_CYCLES = DIV_W'(HALF_BIT_CYC)
) (
	input  wire logic                 SYS_CLK_I,
	input  wire logic                 RESET_N_I,
	input  wire logic                 CLK_EN_I,
	input  wire tpm_mode_t            MODE_I,
	input  wire logic                 STEP_I,
	input  wire logic                 BURST_I,
	input  wire logic                 BURST_SEL_I,
	input  wire logic                 LONG_STOP_I,
	input  wire logic                 MARK_HIGH_I,
	input  wire logic [6:0]           MSG_LEN_I,
	input  wire logic [DIV_W-1:0]     HALF_BIT_I,
	input  wire logic                 TBL_WE_I,
	input  wire logic [6:0]           TBL_ADDR_I,
	input  wire logic [DATA_BITS-1:0] TBL_DATA_I,
	output logic                      LINE_O,
	output logic                      MARK_O,
	output tpm_flags_t                FLAGS_O,
	output logic [3:0]                UNITS_O,
	output logic [3:0]                TENS_O,
	output logic [COLS-1:0]           UNITS_SEL_O,
	output logic [ROWS-1:0]           TENS_SEL_O,
	output logic                      CHAR_DONE_O
);
	////////////////////////////////////////////////////////////////
	// pin synchronisers
	logic [1:0]           step_sync;
	logic [1:0]           burst_sync;
	logic                 step_lvl;
	logic                 burst_lvl;
	logic                 running;
	logic                 transfer;
	logic                 empty;
	logic                 stop_tmg;
	logic                 burst;
	logic                 out_stage;
	logic [DATA_BITS-1:0] data_stg;
	logic                 stop_ins;
	logic                 space_fill;
	logic [DIV_W-1:0]     div;
	logic                 phase;
	logic                 ph2;
	logic                 ph1;
	logic                 base_run;
	logic                 wrap;
	logic [3:0]           units;
	logic [3:0]           tens;
	logic                 len_hit;
	logic                 cnt_clr;
	logic                 step_req;
	logic                 sense_empty;
	logic                 run_fall;
	logic [DATA_BITS-1:0] table_q [CHARS];
	logic [DATA_BITS-1:0] mat_data;
	logic [6:0]           pos;
	tpm_state_t           state;
	logic [6:0]           len_eff;

	always_ff @(posedge SYS_CLK_I) begin
		if (!RESET_N_I) begin
			step_sync  <= 2'h0;
			burst_sync <= 2'h0;
		end else if (CLK_EN_I) begin
			step_sync  <= {step_sync[0], STEP_I};
			burst_sync <= {burst_sync[0], BURST_I};
		end
	end
	assign step_lvl  = step_sync[1];
	assign burst_lvl = burst_sync[1];

	////////////////////////////////////////////////////////////////
	// time base
	// divider two phases
	assign base_run = running | empty;
	// earliest of port and parameter ends each half bit
	assign wrap     = (div >= HALF_BIT_I - DIV_W'(1)) || (div >= HALF_BIT_CYCLES - DIV_W'(1));
	always_ff @(posedge SYS_CLK_I) begin
		if (!RESET_N_I) begin
			div   <= '0;
			phase <= 1'b1;
		end else if (CLK_EN_I) begin
			if (!base_run) begin
				// parked so the first strobe is phase two: one-unit start
				div   <= '0;
				phase <= 1'b1;
			end else if (wrap) begin
				div   <= '0;
				phase <= ~phase;
			end else begin
				div <= div + DIV_W'(1);
			end
		end
	end
	// ph2: zero-going edge, ph1: positive edge, half a bit apart
	assign ph2 = base_run && wrap && phase;
	assign ph1 = base_run && wrap && !phase;

	////////////////////////////////////////////////////////////////
	// step gate
	// step level and burst flag feed the gate
	assign step_req = (MODE_I == TPM_MODE_RUN) ||
	                  (MODE_I == TPM_MODE_STEP && (BURST_SEL_I ? burst : step_lvl));
	assign sense_empty = (MODE_I != TPM_MODE_REV) && (out_stage == MARK) && running &&
	                     !stop_ins && !space_fill && (data_stg == '0) && !transfer;
	assign run_fall = running && empty && ph2 && (MODE_I != TPM_MODE_REV);

	////////////////////////////////////////////////////////////////
	// control flags
	always_ff @(posedge SYS_CLK_I) begin
		if (!RESET_N_I) begin
			running  <= 1'b0;
			transfer <= 1'b0;
			empty    <= 1'b0;
			stop_tmg <= 1'b1;
			state    <= TPM_IDLE;
		end else if (CLK_EN_I) begin
			if (MODE_I == TPM_MODE_REV) begin
				running <= 1'b1;
				empty   <= 1'b0;
				state   <= TPM_FRAME;
			end else if (!running && !empty) begin
				if (step_req && MODE_I != TPM_MODE_MARK) begin
					running  <= 1'b1;
					transfer <= 1'b1;
					state    <= TPM_FRAME;
				end else begin
					state <= TPM_IDLE;
				end
			end else begin
				if (transfer && ph2)
					transfer <= 1'b0;
				if (sense_empty) begin
					empty <= 1'b1;
					state <= TPM_EMPTY;
				end
				if (run_fall) begin
					running  <= 1'b0;
					stop_tmg <= 1'b0;
					state    <= TPM_STOP;
				end
				if (!stop_tmg && !running && ph2)
					stop_tmg <= 1'b1;
				// short stop, half bit after running clears
				if (empty && !running && !LONG_STOP_I && ph1 && stop_ins) begin
					empty    <= 1'b0;
					// base halts before any phase two, so restore rest value
					stop_tmg <= 1'b1;
					state    <= TPM_IDLE;
				end
				// long stop ends as stop timing sets
				if (empty && !running && LONG_STOP_I && !stop_tmg && ph2 && stop_ins) begin
					empty <= 1'b0;
					state <= TPM_IDLE;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// shift register
	always_ff @(posedge SYS_CLK_I) begin
		if (!RESET_N_I) begin
			out_stage  <= MARK;
			data_stg   <= '0;
			stop_ins   <= MARK;
			space_fill <= SPACE;
		end else if (CLK_EN_I) begin
			if (MODE_I == TPM_MODE_REV) begin
				if (ph1)
					out_stage <= ~out_stage;
			end else if (!running && !empty) begin
				out_stage <= (step_req && MODE_I != TPM_MODE_MARK) ? SPACE : MARK;
				stop_ins  <= MARK;
			end else if (!running) begin
				out_stage <= MARK;
				stop_ins  <= MARK;
			end else if (transfer && ph2) begin
				data_stg <= mat_data;
			end else if (ph1 && !empty && !transfer) begin
				// shift toward output, blocked by empty
				out_stage  <= data_stg[0];
				data_stg   <= {stop_ins, data_stg[DATA_BITS-1:1]};
				stop_ins   <= space_fill;
				space_fill <= SPACE;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// scan counters and table
	assign len_eff = (MSG_LEN_I < LEN_MIN || MSG_LEN_I > LEN_MAX) ? LEN_RST : MSG_LEN_I;
	assign pos     = 7'(tens * 4'hA) + 7'(units);
	assign len_hit = run_fall && (pos + 7'h01 >= len_eff);
	assign cnt_clr = len_hit;

	always_ff @(posedge SYS_CLK_I) begin
		if (!RESET_N_I) begin
			units <= DIGIT_RST;
			tens  <= DIGIT_RST;
		end else if (CLK_EN_I) begin
			if (cnt_clr) begin
				units <= DIGIT_RST;
				tens  <= DIGIT_RST;
			end else if (run_fall) begin
				if (units == DIGIT_MAX) begin
					units <= DIGIT_RST;
					tens  <= tens + 4'h1;
				end else begin
					units <= units + 4'h1;
				end
			end
		end
	end

	always_ff @(posedge SYS_CLK_I) begin
		if (!RESET_N_I)
			burst <= 1'b0;
		else if (CLK_EN_I) begin
			if (burst_lvl)
				burst <= 1'b1;
			else if (cnt_clr)
				burst <= 1'b0;
		end
	end

	always_ff @(posedge SYS_CLK_I) begin
		if (CLK_EN_I && TBL_WE_I && TBL_ADDR_I < 7'(CHARS))
			table_q[TBL_ADDR_I] <= TBL_DATA_I;
	end
	assign mat_data = (pos < 7'(CHARS)) ? table_q[pos] : '0;

	genvar gi;
	generate
		for (gi = 0; gi < COLS; gi++) begin : g_units
			assign UNITS_SEL_O[gi] = (units == 4'(gi));
		end
		for (gi = 0; gi < ROWS; gi++) begin : g_tens
			assign TENS_SEL_O[gi] = (tens == 4'(gi));
		end
	endgenerate

	////////////////////////////////////////////////////////////////
	// outputs
	always_ff @(posedge SYS_CLK_I) begin
		if (!RESET_N_I) begin
			// idle line shows mark in either polarity
			LINE_O      <= MARK_HIGH_I;
			MARK_O      <= MARK;
			CHAR_DONE_O <= 1'b0;
		end else if (CLK_EN_I) begin
			LINE_O      <= MARK_HIGH_I ? out_stage : ~out_stage;
			MARK_O      <= out_stage;
			CHAR_DONE_O <= run_fall;
		end
	end
	assign FLAGS_O = '{running: running, transfer: transfer, empty: empty,
	                   stop_tmg: stop_tmg, burst: burst};
	assign UNITS_O = units;
	assign TENS_O  = tens;

	////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge SYS_CLK_I); endclocking
	default disable iff (!RESET_N_I);

	start_space_a: assert property (CLK_EN_I && !running && !empty && step_req
		&& MODE_I != TPM_MODE_MARK && MODE_I != TPM_MODE_REV |=> running && transfer && !out_stage)
		else $error("frame start not formed");
	mark_block_a: assert property (CLK_EN_I && MODE_I == TPM_MODE_MARK && !running && !empty
		|=> !running)
		else $error("steady mark started a frame");
	empty_shift_a: assert property (empty && MODE_I != TPM_MODE_REV && $stable(MODE_I)
		|=> $stable(data_stg))
		else $error("shift while empty");
	run_clear_a: assert property (run_fall && CLK_EN_I |=> !running && out_stage == MARK)
		else $error("running not cleared");
	units_adv_a: assert property (run_fall && CLK_EN_I && !cnt_clr && units != DIGIT_MAX
		|=> units == $past(units) + 4'h1)
		else $error("units did not advance");
	tens_adv_a: assert property (run_fall && CLK_EN_I && !cnt_clr && units == DIGIT_MAX
		|=> units == DIGIT_RST && tens == $past(tens) + 4'h1)
		else $error("tens did not advance");
	len_reset_a: assert property (cnt_clr && CLK_EN_I && !burst_lvl
		|=> units == DIGIT_RST && tens == DIGIT_RST && !burst)
		else $error("length reset failed");
	rev_force_a: assert property (CLK_EN_I && MODE_I == TPM_MODE_REV |=> running && !empty)
		else $error("reversals not forced");
	polarity_a: assert property (CLK_EN_I |=> LINE_O == ($past(MARK_HIGH_I) ~^ $past(out_stage)))
		else $error("line polarity wrong");
	base_idle_a: assert property (!base_run |-> !ph1 && !ph2)
		else $error("time base ran idle");
	state_flags_a: assert property ({running, empty} == {state[0], state[1]})
		else $error("state and flags disagree");

	frame_c: cover property (running ##1 empty ##[1:8] !running);
	wrap_c: cover property (run_fall && units == DIGIT_MAX);
	len_c: cover property (cnt_clr);
	rev_c: cover property (MODE_I == TPM_MODE_REV && ph1);
endmodule // tpm_serializer

/* src/tpm_pkg.sv */
package tpm_pkg;
	localparam int unsigned CLK_HZ        = 20_000_000;
	localparam int unsigned BAUD_DEF      = 50;
	// half-bit count: phase strobes alternate at this spacing
	localparam int unsigned HALF_BIT_CYC  = CLK_HZ / (2 * BAUD_DEF);
	localparam int unsigned DIV_W         = 24;
	localparam int unsigned DATA_BITS     = 5;
	localparam int unsigned ROWS          = 8;
	localparam int unsigned COLS          = 10;
	localparam int unsigned CHARS         = ROWS * COLS;
	localparam logic [3:0]  DIGIT_MAX     = 4'h9;
	localparam logic [6:0]  LEN_MIN       = 7'h01;
	localparam logic [6:0]  LEN_MAX       = 7'h50;
	localparam logic [6:0]  LEN_RST       = 7'h50;
	localparam logic [3:0]  DIGIT_RST     = 4'h0;
	localparam logic        MARK          = 1'b1;
	localparam logic        SPACE         = 1'b0;

	typedef enum logic [1:0] {
		TPM_MODE_STEP = 2'b00,
		TPM_MODE_RUN  = 2'b01,
		TPM_MODE_REV  = 2'b11,
		TPM_MODE_MARK = 2'b10
	} tpm_mode_t;

	// gray along idle -> frame -> empty -> stop
	typedef enum logic [1:0] {
		TPM_IDLE  = 2'b00,
		TPM_FRAME = 2'b01,
		TPM_EMPTY = 2'b11,
		TPM_STOP  = 2'b10
	} tpm_state_t;

	typedef struct packed {
		logic       running;
		logic       transfer;
		logic       empty;
		logic       stop_tmg;
		logic       burst;
	} tpm_flags_t;
endpackage

/* tb/tpm_line_rx.sv */
`timescale 1ns/1ns
// far-end receiver: samples mid-unit, no clock of its own
module tpm_line_rx #(
	parameter int HALF = 4
) (
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	input  wire logic       line_i,
	input  wire logic       mark_high_i,
	output logic [4:0]      char_o,
	output logic            stop_o,
	output int              count_o
);
	initial begin
		char_o = 5'h00;
		stop_o = 1'b0;
		count_o = 0;
		forever begin
			@(posedge clk_i);
			// space is inverse of mark level
			if (rst_n_i && line_i !== mark_high_i) begin
				repeat (3 * HALF - 1) @(posedge clk_i);
				for (int b = 0; b < 5; b++) begin
					char_o[b] = (line_i === mark_high_i);
					repeat (2 * HALF) @(posedge clk_i);
				end
				stop_o = (line_i === mark_high_i);
				count_o++;
			end
		end
	end
endmodule // tpm_line_rx

/* tb/tb_tpm_serializer.sv */
`timescale 1ns/1ns
module tb_tpm_serializer;
	import tpm_pkg::*;
	localparam int HB = 4;
	logic       clk = 1'b0, rst_n = 1'b0, step = 1'b0, burst = 1'b0, bsel = 1'b0;
	logic       long_stop = 1'b0, mark_high = 1'b1, we = 1'b0, en = 1'b1;
	tpm_mode_t  mode = TPM_MODE_STEP;
	logic [6:0] len = 7'h50, addr = 7'h00;
	logic [4:0] data = 5'h00, rx_char;
	logic       line, mark, done, rx_stop;
	tpm_flags_t flags;
	logic [3:0] units, tens;
	logic [9:0] usel;
	logic [7:0] tsel;
	int         rx_count, err_total = 0, tests_run = 0;

	always #25 clk = ~clk;

	tpm_serializer #(.HALF_BIT_CYCLES(DIV_W'(HB))) tpm_serializer_i (
		.SYS_CLK_I(clk), .RESET_N_I(rst_n), .CLK_EN_I(en), .MODE_I(mode),
		.STEP_I(step), .BURST_I(burst), .BURST_SEL_I(bsel), .LONG_STOP_I(long_stop),
		.MARK_HIGH_I(mark_high), .MSG_LEN_I(len), .HALF_BIT_I(DIV_W'(HB)),
		.TBL_WE_I(we), .TBL_ADDR_I(addr), .TBL_DATA_I(data), .LINE_O(line),
		.MARK_O(mark), .FLAGS_O(flags), .UNITS_O(units), .TENS_O(tens),
		.UNITS_SEL_O(usel), .TENS_SEL_O(tsel), .CHAR_DONE_O(done));
	tpm_line_rx #(.HALF(HB)) tpm_line_rx_i (.clk_i(clk), .rst_n_i(rst_n),
		.line_i(line), .mark_high_i(mark_high), .char_o(rx_char),
		.stop_o(rx_stop), .count_o(rx_count));

	////////////////////////////////////////////////////////////////////////
	function automatic logic [4:0] pat(int a);
		return 5'(a * 7 + 3);
	endfunction
	task automatic tk(int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic chk(string n, logic [31:0] e, logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			err_total++;
			$display("MISMATCH %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic hang(string n);
		err_total++;
		$display("MISMATCH %s exp done got timeout", n);
		print_verdict();
	endtask
	task automatic do_reset();
		tk(1);
		rst_n = 1'b0;
		tk(2);
		rst_n = 1'b1;
		tk(3);
	endtask
	task automatic get_char(int t, int pos);
		for (int i = 0; i < 2000; i++) begin
			if (rx_count >= t) begin
				chk("char", pat(pos), rx_char);
				chk("stop", 1'b1, rx_stop);
				return;
			end
			tk(1);
		end
		hang("rx");
	endtask
	task automatic wait_idle();
		for (int i = 0; i < 500; i++) begin
			tk(1);
			if (flags.running === 1'b0 && flags.empty === 1'b0) return;
		end
		hang("idle");
	endtask
	task automatic pulse(ref logic s);
		tk(1);
		s = 1'b1;
		tk(4);
		s = 1'b0;
	endtask
	task automatic per(output int p);
		int c;
		c = 0;
		for (int i = 0; i < 3000 && c < 2; i++) begin
			tk(1);
			if (done === 1'b1) begin
				p = (c == 1) ? i - p : i;
				c++;
			end
		end
		if (c < 2) hang("done");
	endtask

	////////////////////////////////////////////////////////////////////////
	task automatic s_idle();
		do_reset();
		chk("line", 1'b1, line);
		chk("flags", 5'b00010, flags);
		chk("tens_units", 8'h00, {tens, units});
		chk("sel", 18'h00401, {tsel, usel});
		for (int a = 0; a < CHARS; a++) begin
			tk(1);
			we = 1'b1;
			addr = 7'(a);
			data = pat(a);
		end
		tk(1);
		we = 1'b0;
	endtask
	task automatic s_step();
		int n;
		n = rx_count;
		pulse(step);
		tk(2);
		chk("run_start", 2'b10, {flags.running, mark});
		get_char(n + 1, 0);
		tk(150);
		chk("one_char", 10'(n + 1), 10'(rx_count));
		wait_idle();
		chk("units", 14'h0402, {units, usel});
	endtask
	task automatic s_mark();
		int n;
		n = rx_count;
		mode = TPM_MODE_MARK;
		step = 1'b1;
		tk(200);
		chk("mark_idle", {10'(n), 1'b1}, {10'(rx_count), line});
		step = 1'b0;
		// let the synchronised step drain before step mode opens the gate
		tk(3);
		mode = TPM_MODE_STEP;
	endtask
	task automatic s_run();
		int n;
		do_reset();
		len = 7'h0C;
		n = rx_count;
		mode = TPM_MODE_RUN;
		// crossing units nine into tens, then length wrap
		for (int k = 0; k < 14; k++) get_char(n + k + 1, k % 12);
		mode = TPM_MODE_STEP;
		wait_idle();
		len = 7'h50;
	endtask
	task automatic s_stop();
		int p1, p2;
		mode = TPM_MODE_RUN;
		per(p1);
		long_stop = 1'b1;
		per(p2);
		chk("long_stop", 10'(HB), 10'(p2 - p1));
		mode = TPM_MODE_STEP;
		long_stop = 1'b0;
		wait_idle();
	endtask
	task automatic s_hold();
		en = 1'b0;
		mode = TPM_MODE_RUN;
		tk(20);
		chk("hold", 2'b01, {flags.running, line});
		en = 1'b1;
		tk(3);
		chk("resume", 1'b1, flags.running);
		mode = TPM_MODE_STEP;
		wait_idle();
	endtask
	task automatic s_pol();
		int n;
		// polarity moves only under reset, else the far end sees a false start
		tk(1);
		rst_n = 1'b0;
		mark_high = 1'b0;
		do_reset();
		chk("line_low", 1'b0, line);
		n = rx_count;
		pulse(step);
		get_char(n + 1, 0);
		wait_idle();
		tk(1);
		rst_n = 1'b0;
		mark_high = 1'b1;
		do_reset();
	endtask
	task automatic s_burst();
		int n;
		len = 7'h03;
		bsel = 1'b1;
		n = rx_count;
		pulse(burst);
		for (int k = 0; k < 3; k++) get_char(n + k + 1, k);
		tk(200);
		chk("burst_end", 10'(n + 3), 10'(rx_count));
		chk("burst_flag", 1'b0, flags.burst);
		bsel = 1'b0;
		len = 7'h50;
	endtask
	task automatic s_rev();
		int tg;
		logic prev;
		tg = 0;
		do_reset();
		mode = TPM_MODE_REV;
		tk(8);
		prev = line;
		for (int i = 0; i < 20 * HB; i++) begin
			tk(1);
			if (line !== prev) tg++;
			prev = line;
		end
		// one toggle per unit: ten units in the window
		chk("rev", 2'b11, {flags.running, 1'(tg >= 9 && tg <= 11)});
		mode = TPM_MODE_STEP;
	endtask

	initial begin
		s_idle();
		s_step();
		s_mark();
		s_run();
		s_stop();
		s_hold();
		s_pol();
		s_burst();
		s_rev();
		print_verdict();
	end
endmodule // tb_tpm_serializer
